// *** design/impact_pkg.sv ***
package impact_pkg;
    // converter scaling
    localparam logic [7:0] full_scale = 8'hFF;           // count at reference voltage
    localparam logic [7:0] nominal_zero = 8'h80;         // count near 0 g
    localparam int ref_millivolts = 5000;                 // shared supply reference
    localparam int half_g_per_count = 1;                  // half a g per count
    // timing in own units
    localparam int clk_hz = 50_000_000;
    localparam int sample_period_us = 650;
    localparam int cal_time_ms = 4000;
    localparam int hold_time_ms = 3000;
    localparam int lcd_toggle_hz = 30;
    localparam int sample_cycles = sample_period_us * (clk_hz / 1_000_000);
    localparam int cal_cycles = cal_time_ms * (clk_hz / 1000);
    localparam int hold_cycles = hold_time_ms * (clk_hz / 1000);
    localparam int lcd_half_cycles = clk_hz / (2 * lcd_toggle_hz);
    // impact threshold in half-g units (7 g)
    localparam logic [8:0] led_threshold = 9'h00E;
    // calibration and averaging sample counts as shift widths
    localparam int cal_shift = 12;                        // at most 4095 samples taken in 4 s window
    localparam int avg_shift = 6;                         // 64 samples, low-g or negative
    localparam int low_g_counts = 4;                      // default low-g boundary

    typedef enum logic [1:0] {
        st_cal = 2'b00,
        st_run = 2'b01
    } mode_t;

    typedef struct packed {
        logic negative;          // minus indicator
        logic [8:0] half_g;      // magnitude in half-g units
    } reading_t;
endpackage : impact_pkg

// *** design/impact_peak_hold_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module impact_peak_hold_monitor
    import impact_pkg::*;
#(
    parameter int low_g_limit = low_g_counts,            // counts from offset
    parameter int sample_period = sample_cycles,
    parameter int cal_period = cal_cycles,
    parameter int hold_period = hold_cycles,
    parameter int lcd_half_period = lcd_half_cycles
) (
    input wire logic clk,                  // 50 MHz system clock
    input wire logic rst,                  // synchronous reset, active high
    input wire logic [7:0] adc_count,      // converter result
    input wire logic adc_valid,            // strobe with result, must stay high two cycles
    output logic adc_start,                // conversion request pulse
    output logic cal_banner,               // calibration banner shown
    output logic [9:0] display_value,      // sign and half-g magnitude
    output logic [10:0] lcd_segments,      // segment lines, ac driven
    output logic lcd_backplane,            // backplane line
    output logic pulse_length_output       // LED drive
);
    initial begin
        if (low_g_limit < 1 || low_g_limit > 127 || sample_period < 2 ||
            cal_period < 2 || hold_period < 2 || lcd_half_period < 2) begin
            $error("impact_peak_hold_monitor: parameter out of range");
        end
    end

    mode_t mode;
    logic [31:0] sample_cnt;
    logic [31:0] cal_cnt;
    logic [31:0] hold_cnt;
    logic [31:0] led_cnt;
    logic [31:0] lcd_cnt;
    logic [19:0] cal_acc;
    logic [11:0] cal_num;
    logic [7:0] zero_offset;
    logic [13:0] avg_acc;
    logic [6:0] avg_num;
    logic holding;
    reading_t shown;
    logic [7:0] adc_q1, adc_q2, adc_q3;
    logic valid_q1, valid_q2, valid_q3, valid_seen;
    logic fresh;
    logic [7:0] sample;
    reading_t next_reading;
    logic low_g;

    // converter outputs pass three flops, taken when last two agree
    always_ff @(posedge clk) begin
        if (rst) begin
            adc_q1 <= 8'h00;
            adc_q2 <= 8'h00;
            adc_q3 <= 8'h00;
            valid_q1 <= 1'b0;
            valid_q2 <= 1'b0;
            valid_q3 <= 1'b0;
            valid_seen <= 1'b0;
        end else begin
            adc_q1 <= adc_count;
            adc_q2 <= adc_q1;
            adc_q3 <= adc_q2;
            valid_q1 <= adc_valid;
            valid_q2 <= valid_q1;
            valid_q3 <= valid_q2;
            valid_seen <= valid_q2 & valid_q3;
        end
    end

    assign fresh = valid_q2 & valid_q3 & ~valid_seen & (adc_q2 == adc_q3);
    assign sample = adc_q3;

    // conversion pacing every sample period
    always_ff @(posedge clk) begin
        if (rst) begin
            sample_cnt <= 32'h0000_0000;
            adc_start <= 1'b0;
        end else if (sample_cnt == 32'(sample_period - 1)) begin
            sample_cnt <= 32'h0000_0000;
            adc_start <= 1'b1;
        end else begin
            sample_cnt <= sample_cnt + 32'h0000_0001;
            adc_start <= 1'b0;
        end
    end

    // power-up calibration and offset store
    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= st_cal;
            cal_cnt <= 32'h0000_0000;
            cal_acc <= 20'h00000;
            cal_num <= 12'h000;
            zero_offset <= nominal_zero;
            cal_banner <= 1'b1;
        end else begin
            case (mode)
                st_cal: begin
                    cal_cnt <= cal_cnt + 32'h0000_0001;
                    if (fresh && cal_num != 12'hFFF) begin
                        cal_acc <= cal_acc + {12'h000, sample};
                        cal_num <= cal_num + 12'h001;
                    end
                    if (cal_cnt == 32'(cal_period - 1)) begin
                        mode <= st_run;
                        cal_banner <= 1'b0;
                        if (cal_num != 12'h000) begin
                            zero_offset <= 8'((cal_acc + {9'h000, cal_num[11:1]}) / {8'h00, cal_num});
                        end
                    end
                end
                st_run: cal_banner <= 1'b0;
                default: mode <= st_cal;
            endcase
        end
    end

    // signed difference from offset in half-g units
    function automatic reading_t to_reading(input logic [7:0] cnt, input logic [7:0] zero);
        reading_t r;
        r.negative = (cnt < zero);
        r.half_g = r.negative ? {1'b0, zero - cnt} : {1'b0, cnt - zero};
        return r;
    endfunction : to_reading

    assign next_reading = to_reading(sample, zero_offset);
    assign low_g = next_reading.half_g < 9'(low_g_limit);

    // peak hold, low-g averaging and display value
    always_ff @(posedge clk) begin
        if (rst) begin
            shown <= '0;
            holding <= 1'b0;
            hold_cnt <= 32'h0000_0000;
            avg_acc <= 14'h0000;
            avg_num <= 7'h00;
        end else if (mode == st_run) begin
            if (holding) begin
                if (hold_cnt == 32'(hold_period - 1)) begin
                    holding <= 1'b0;
                    shown <= '0;
                end else begin
                    hold_cnt <= hold_cnt + 32'h0000_0001;
                end
            end
            if (fresh && !low_g && !next_reading.negative) begin
                if (!holding || shown.negative || next_reading.half_g > shown.half_g) begin
                    shown <= next_reading;
                    holding <= 1'b1;
                    hold_cnt <= 32'h0000_0000;
                end
            end else if (fresh && !holding) begin
                if (avg_num == 7'(1 << avg_shift) - 7'h01) begin
                    shown <= to_reading(8'((avg_acc + {6'h00, sample}) >> avg_shift),
                                        zero_offset);
                    avg_acc <= 14'h0000;
                    avg_num <= 7'h00;
                end else begin
                    avg_acc <= avg_acc + {6'h00, sample};
                    avg_num <= avg_num + 7'h01;
                end
            end
        end
    end

    // LED on three seconds for seven g or more
    always_ff @(posedge clk) begin
        if (rst) begin
            led_cnt <= 32'h0000_0000;
            pulse_length_output <= 1'b0;
        end else if (mode == st_run && fresh && !next_reading.negative &&
                     next_reading.half_g >= led_threshold) begin
            led_cnt <= 32'h0000_0000;
            pulse_length_output <= 1'b1;
        end else if (pulse_length_output) begin
            if (led_cnt == 32'(hold_period - 1)) begin
                pulse_length_output <= 1'b0;
            end else begin
                led_cnt <= led_cnt + 32'h0000_0001;
            end
        end
    end

    // registered display value and ac drive of lcd
    always_ff @(posedge clk) begin
        if (rst) begin
            display_value <= 10'h000;
            lcd_cnt <= 32'h0000_0000;
            lcd_backplane <= 1'b0;
            lcd_segments <= 11'h400; // banner lit, backplane low
        end else begin
            display_value <= {shown.negative, shown.half_g};
            if (lcd_cnt == 32'(lcd_half_period - 1)) begin
                lcd_cnt <= 32'h0000_0000;
                lcd_backplane <= ~lcd_backplane;
            end else begin
                lcd_cnt <= lcd_cnt + 32'h0000_0001;
            end
            // lit segments are opposite the backplane phase
            lcd_segments <= {11{lcd_backplane}} ^
                            {cal_banner, shown.negative, shown.half_g};
        end
    end
endmodule : impact_peak_hold_monitor
`default_nettype wire

// *** verification/impact_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module impact_checker
    import impact_pkg::*;
#(
    parameter int low_g_limit = 4,
    parameter int sample_period = 20,
    parameter int cal_period = 200,
    parameter int hold_period = 100,
    parameter int lcd_half_period = 8
) (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic adc_start, // request
    input wire logic cal_banner, // banner
    input wire logic [9:0] display_value, // shown value
    input wire logic [10:0] lcd_segments, // segments
    input wire logic lcd_backplane, // backplane
    input wire logic pulse_length_output // led
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    int sc, bc, lc, hc, cc;
    logic sv, bv, hd;
    // cycles since each event, and held-peak flag
    always_ff @(posedge clk) begin
        sc <= (rst || adc_start) ? 0 : sc + 1;
        bc <= (rst || $changed(lcd_backplane)) ? 0 : bc + 1;
        lc <= pulse_length_output ? lc + 1 : 0;
        hc <= (rst || $changed(display_value)) ? 0 : hc + 1;
        cc <= rst ? 0 : cc + 1;
        sv <= !rst && (sv || adc_start);
        bv <= !rst && (bv || $changed(lcd_backplane));
        hd <= !display_value[9] && display_value[8:0] >= low_g_limit;
    end
    AST_START: assert property (sv |->
        (adc_start ? sc == sample_period - 1 : sc < sample_period - 1))
        else $error("conversion request spacing wrong");
    AST_BP: assert property (bv |->
        ($changed(lcd_backplane) ? bc == lcd_half_period - 1 : bc < lcd_half_period - 1))
        else $error("backplane toggle spacing wrong");
    AST_SEG: assert property ($stable(lcd_backplane) && $stable(cal_banner) &&
        $stable(display_value) |->
        lcd_segments == ({cal_banner, display_value} ^ {11{lcd_backplane}}))
        else $error("segment lines not in phase with backplane");
    AST_RESET: assert property (disable iff (1'b0) rst |=>
        cal_banner && display_value == 10'h000 && !pulse_length_output && !adc_start)
        else $error("reset state wrong");
    AST_CAL_END: assert property ($fell(cal_banner) |-> cc >= cal_period - 1)
        else $error("calibration ended early");
    AST_CAL_ONCE: assert property (cal_banner |-> cc < cal_period + 2 * sample_period)
        else $error("calibration banner stays too long");
    AST_LED_ON: assert property ($rose(pulse_length_output) |->
        ##1 (!display_value[9] && display_value[8:0] >= led_threshold))
        else $error("led lit below threshold");
    AST_LED_TIME: assert property ($fell(pulse_length_output) |-> lc >= hold_period - 1)
        else $error("led pulse too short");
    AST_HOLD_UP: assert property ($changed(display_value) && hd |->
        display_value == 10'h000 || display_value[8:0] > $past(display_value[8:0])
        && !display_value[9]) else $error("held peak replaced by smaller value");
    AST_HOLD_TIME: assert property ($changed(display_value) && hd &&
        display_value == 10'h000 |-> hc >= hold_period - 2) else $error("held peak cleared early");
    cover property ($rose(pulse_length_output));
    cover property ($fell(cal_banner));
    cover property (display_value[9]);
endmodule : impact_checker
bind impact_peak_hold_monitor impact_checker #(.low_g_limit(low_g_limit),
    .sample_period(sample_period), .cal_period(cal_period), .hold_period(hold_period),
    .lcd_half_period(lcd_half_period)) i_chk (.clk(clk), .rst(rst), .adc_start(adc_start),
    .cal_banner(cal_banner), .display_value(display_value), .lcd_segments(lcd_segments),
    .lcd_backplane(lcd_backplane), .pulse_length_output(pulse_length_output));
`default_nettype wire

// *** verification/adc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_model (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic adc_start, // request
    input wire logic slow, // late answer
    input wire logic [7:0] level, // sensor count
    output logic [7:0] adc_count, // result
    output logic adc_valid // result strobe
);
    int cnt;
    logic [7:0] lvl;
    logic [7:0] req_level;
    logic req, req_slow, rst_q;
    // request, level and mode taken at the rising edge, clear of bench stimulus
    always @(posedge clk) begin
        req <= adc_start;
        req_level <= level;
        req_slow <= slow;
        rst_q <= rst;
    end
    // latch level on request, strobe four cycles, garbage otherwise
    always @(negedge clk) begin
        if (rst_q) begin
            cnt <= 0;
        end else if (req) begin
            cnt <= req_slow ? 10 : 5;
            lvl <= req_level;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
        adc_valid <= !rst_q && cnt > 0 && cnt <= 4;
        adc_count <= (cnt > 0 && cnt <= 4) ? lvl : ~lvl;
    end
endmodule : adc_model
`default_nettype wire

// *** verification/impact_peak_hold_monitor_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module impact_peak_hold_monitor_tb;
    import impact_pkg::*;
    logic clk = 1'b0, rst = 1'b1, slow = 1'b0;
    logic [7:0] level = 8'h80;
    wire logic adc_valid, adc_start, cal_banner, lcd_backplane, led;
    wire logic [7:0] adc_count;
    wire logic [9:0] display_value;
    wire logic [10:0] lcd_segments;
    int miscompares = 0, tests_run = 0, n;
    // rows: level, wait, expected {led, display}
    logic [7:0] lv [7] = '{8'h8D, 8'h84, 8'h8F, 8'h80, 8'h82, 8'h7E, 8'h70};
    int wt [7] = '{40, 40, 40, 140, 2800, 2800, 2800};
    logic [10:0] ex [7] = '{11'h00D, 11'h00D, 11'h40F, 11'h000, 11'h002, 11'h202, 11'h210};
    always #10 clk = ~clk;
    impact_peak_hold_monitor #(.sample_period(20), .cal_period(200), .hold_period(100),
        .lcd_half_period(8)) i_dut (.clk(clk), .rst(rst), .adc_count(adc_count),
        .adc_valid(adc_valid), .adc_start(adc_start), .cal_banner(cal_banner),
        .display_value(display_value), .lcd_segments(lcd_segments),
        .lcd_backplane(lcd_backplane), .pulse_length_output(led));
    adc_model i_adc (.clk(clk), .rst(rst), .adc_start(adc_start), .slow(slow),
        .level(level), .adc_count(adc_count), .adc_valid(adc_valid));
    // compare and count
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc
    // bounded wait for calibration end
    task automatic cal_wait;
        for (n = 0; n < 400 && cal_banner !== 1'b0; n++) cyc(1);
    endtask : cal_wait
    task wrap_up;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    // main sequence
    initial begin
        cyc(4);
        rst = 1'b0;
        cal_wait();
        check(12'(n >= 200 && n < 400), 12'h001);
        for (int i = 0; i < 7; i++) begin
            level = lv[i];
            slow = i[0];
            cyc(wt[i]);
            check({1'b0, led, display_value}, {1'b0, ex[i]});
        end
        // reset in mid-run, then recalibrate at a shifted zero
        level = 8'h90;
        rst = 1'b1;
        cyc(2);
        check({cal_banner, led, display_value}, 12'h800);
        rst = 1'b0;
        cal_wait();
        level = 8'h9E;
        cyc(40);
        check({cal_banner, led, display_value}, 12'h40E);
        wrap_up();
    end
    // watchdog
    initial begin
        cyc(15000);
        miscompares++;
        wrap_up();
    end
endmodule : impact_peak_hold_monitor_tb
`default_nettype wire
